// file: hdl/lpms_sequencer.sv
`timescale 1ns/1ps
// What this block does
// - A wait-for-interrupt with a mode configured puts the device into that mode.
// - An enabled wake interrupt cancels the low power mode and resumes the core.
// - With deep standby select at 1 a standby entry goes on into deep standby.
// - Snooze and deep standby are only reached through software standby.
// - The system clock source changes only in normal mode.
// - The real-time counter keeps running while the core is halted.
// - The periodic interrupt interval is at most 2 seconds.
// - An enabled alarm match cancels snooze or standby back to normal mode.
// - Two timers cascade and the second underflow can cancel standby or deep standby.
// - Outside deep standby and pin retention, pins configured as disabled are held in input mode.
// - Waking from deep standby resets the device, distinct from power-on reset.
// - After that reset pins stay retained until cleared, and a flag records the cause.
module lpms_sequencer
  import lpms_pkg::*;
#(
  parameter int PIN_W = 8,
  parameter int RTC_W = 32,
  parameter logic [2:0] PERIOD_SEL_MAX = 3'h6
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic slow_tick,
  input wire logic wfi,
  input wire lpms_cfg_t cfg,
  input wire lpms_tmr_cfg_t tmr_cfg,
  input wire logic [2:0] period_sel,
  input wire logic [RTC_W-1:0] alarm_value,
  input wire logic alarm_enable,
  input wire logic irq_pin,
  input wire logic [1:0] clk_src_req,
  input wire logic clk_src_wr,
  input wire logic [PIN_W-1:0] pin_disabled,
  input wire logic [PIN_W-1:0] pin_out,
  input wire logic [PIN_W-1:0] pin_oe,
  input wire logic pin_state_retention_clear,
  input wire logic deep_standby_reset_flag_clear,
  output logic core_halt,
  output logic [3:0] mode_state,
  output logic [1:0] clk_src,
  output logic clk_gate,
  output logic [RTC_W-1:0] rtc_count,
  output logic wake_pulse,
  output logic deep_wake_reset,
  output logic deep_standby_reset_flag,
  output logic pin_state_retention,
  output logic [PIN_W-1:0] pad_out,
  output logic [PIN_W-1:0] pad_oe
);

  typedef enum logic [5:0] {
    LPMS_ST_NORMAL = 6'b00_0001,
    LPMS_ST_SLEEP = 6'b00_0010,
    LPMS_ST_STANDBY = 6'b00_0100,
    LPMS_ST_SNOOZE = 6'b00_1000,
    LPMS_ST_DEEP = 6'b01_0000,
    LPMS_ST_RESTORE = 6'b10_0000
  } lpms_state_t;

  lpms_state_t state_r;
  lpms_state_t state_nxt;
  logic irq_s1_r;
  logic irq_s2_r;
  logic [3:0] settle_r;
  logic [1:0] saved_clk_r;
  logic [2:0] period_r;
  logic [RTC_W-1:0] rtc_r;
  logic [RTC_W-1:0] period_cnt_r;
  logic periodic_evt;
  logic alarm_evt;
  logic timer_evt;
  logic [LPMS_WK_W-1:0] wake_vec;
  logic wake_any;
  logic timer_run;
  logic in_normal;
  logic clk_change_ok;
  logic deep_wake;
  logic [1:0] clk_src_nxt;
  logic [2:0] period_lim;

  // Period select limited so the interval never passes the limit
  assign period_lim = (period_sel > PERIOD_SEL_MAX) ? PERIOD_SEL_MAX : period_sel;

  // Wake event decode
  assign alarm_evt = alarm_enable && (rtc_r == alarm_value) && slow_tick;
  assign periodic_evt = slow_tick && (period_cnt_r == ((RTC_W'(1) << period_r) - RTC_W'(1)));
  assign wake_vec[LPMS_WK_IRQ] = irq_s2_r;
  assign wake_vec[LPMS_WK_ALARM] = alarm_evt;
  assign wake_vec[LPMS_WK_PERIODIC] = periodic_evt;
  assign wake_vec[LPMS_WK_TIMER] = timer_evt;
  assign wake_any = |(wake_vec & cfg.wake_enable);
  assign in_normal = (state_r == LPMS_ST_NORMAL);
  assign clk_change_ok = in_normal && clk_src_wr && !wfi;
  assign clk_src_nxt = clk_change_ok ? clk_src_req : clk_src;
  assign timer_run = (state_r != LPMS_ST_SLEEP);
  assign deep_wake = (state_r == LPMS_ST_DEEP) && wake_any;

  lpms_timer_pair u_timer (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .tick(slow_tick),
    .run(timer_run),
    .cfg(tmr_cfg),
    .second_underflow(timer_evt)
  );

  // Next state of the mode sequence
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      LPMS_ST_NORMAL: begin
        if (wfi) begin
          state_nxt = (cfg.mode_sel == LPMS_SEL_SLEEP) ? LPMS_ST_SLEEP : LPMS_ST_STANDBY;
        end
      end
      LPMS_ST_SLEEP: begin
        if (wake_any) begin
          state_nxt = LPMS_ST_RESTORE;
        end
      end
      LPMS_ST_STANDBY: begin
        if (cfg.deep_standby_select) begin
          state_nxt = LPMS_ST_DEEP;
        end else if (cfg.mode_sel == LPMS_SEL_SNOOZE) begin
          state_nxt = LPMS_ST_SNOOZE;
        end else if (wake_any) begin
          state_nxt = LPMS_ST_RESTORE;
        end
      end
      LPMS_ST_SNOOZE: begin
        if (wake_any) begin
          state_nxt = LPMS_ST_RESTORE;
        end
      end
      LPMS_ST_DEEP: begin
        if (wake_any) begin
          state_nxt = LPMS_ST_NORMAL;
        end
      end
      LPMS_ST_RESTORE: begin
        if (settle_r == 4'h0) begin
          state_nxt = LPMS_ST_NORMAL;
        end
      end
      default: state_nxt = LPMS_ST_NORMAL;
    endcase
  end

  // Interrupt pin synchroniser
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_s1_r <= 1'b0;
      irq_s2_r <= 1'b0;
    end else begin
      irq_s1_r <= irq_pin;
      irq_s2_r <= irq_s1_r;
    end
  end

  // Mode state, clock source and restore countdown
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= LPMS_ST_NORMAL;
      settle_r <= 4'h0;
      saved_clk_r <= LPMS_CLK_RESET;
      clk_src <= LPMS_CLK_RESET;
    end else begin
      state_r <= state_nxt;
      clk_src <= (state_r == LPMS_ST_RESTORE) ? saved_clk_r : clk_src_nxt;
      if (in_normal && wfi) begin
        saved_clk_r <= clk_src;
        // Four bits: the settle count does not fit in three
        settle_r <= 4'(LPMS_CLK_SETTLE_CYC - 1);
      end else if (state_r == LPMS_ST_RESTORE && settle_r != 4'h0) begin
        settle_r <= settle_r - 4'h1;
      end
    end
  end

  // Real-time counter runs in every mode on the slow tick
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rtc_r <= '0;
      period_cnt_r <= '0;
      period_r <= 3'h0;
    end else if (slow_tick) begin
      rtc_r <= rtc_r + RTC_W'(1);
      period_cnt_r <= periodic_evt ? '0 : period_cnt_r + RTC_W'(1);
      if (periodic_evt) begin
        period_r <= period_lim;
      end
    end
  end

  // Deep standby wake flags and pin retention; set wins over clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      deep_wake_reset <= 1'b0;
      deep_standby_reset_flag <= 1'b0;
      pin_state_retention <= 1'b0;
    end else begin
      deep_wake_reset <= deep_wake;
      if (deep_wake) begin
        deep_standby_reset_flag <= 1'b1;
      end else if (deep_standby_reset_flag_clear) begin
        deep_standby_reset_flag <= 1'b0;
      end
      if (state_r == LPMS_ST_DEEP) begin
        pin_state_retention <= 1'b1;
      end else if (pin_state_retention_clear) begin
        pin_state_retention <= 1'b0;
      end
    end
  end

  // Registered outputs: core halt, gates, pads
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      core_halt <= 1'b0;
      mode_state <= 4'h0;
      clk_gate <= 1'b0;
      wake_pulse <= 1'b0;
      rtc_count <= '0;
      pad_out <= '0;
      pad_oe <= '0;
    end else begin
      core_halt <= (state_nxt != LPMS_ST_NORMAL);
      mode_state <= 4'({state_nxt == LPMS_ST_DEEP, state_nxt == LPMS_ST_SNOOZE,
                        state_nxt == LPMS_ST_STANDBY, state_nxt == LPMS_ST_SLEEP});
      clk_gate <= (state_nxt == LPMS_ST_STANDBY) || (state_nxt == LPMS_ST_SNOOZE) ||
                  (state_nxt == LPMS_ST_DEEP);
      wake_pulse <= (state_r != LPMS_ST_NORMAL) && (state_nxt == LPMS_ST_NORMAL);
      rtc_count <= rtc_r;
      if (!(pin_state_retention || state_r == LPMS_ST_DEEP)) begin
        pad_out <= pin_out;
        pad_oe <= pin_oe & ~pin_disabled;
      end
    end
  end

endmodule

// file: hdl/lpms_timer_pair.sv
`timescale 1ns/1ps
module lpms_timer_pair
  import lpms_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic run,
  input wire lpms_tmr_cfg_t cfg,
  output logic second_underflow
);

  logic [15:0] first_r;
  logic [15:0] second_r;
  logic first_uf;
  logic second_uf;

  // Underflow decode: a counter at zero on its own count enable
  assign first_uf = run && tick && (first_r == 16'h0000);
  assign second_uf = first_uf && (second_r == 16'h0000);

  // First channel counts the slow tick, second counts first underflows
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      first_r <= LPMS_TMR_RESET;
      second_r <= LPMS_TMR_RESET;
      second_underflow <= 1'b0;
    end else if (!run) begin
      first_r <= cfg.first_reload;
      second_r <= cfg.second_reload;
      second_underflow <= 1'b0;
    end else begin
      if (tick) begin
        first_r <= first_uf ? cfg.first_reload : first_r - 16'h0001;
      end
      if (first_uf) begin
        second_r <= second_uf ? cfg.second_reload : second_r - 16'h0001;
      end
      second_underflow <= second_uf;
    end
  end

endmodule

// file: include/lpms_pkg.sv
package lpms_pkg;

  // Mode select codes written by the core before it waits
  localparam logic [1:0] LPMS_SEL_SLEEP = 2'h0;
  localparam logic [1:0] LPMS_SEL_STANDBY = 2'h1;
  localparam logic [1:0] LPMS_SEL_SNOOZE = 2'h2;

  // Wake source bit positions
  localparam int LPMS_WK_IRQ = 0;
  localparam int LPMS_WK_ALARM = 1;
  localparam int LPMS_WK_PERIODIC = 2;
  localparam int LPMS_WK_TIMER = 3;
  localparam int LPMS_WK_W = 4;

  // Reset values
  localparam logic [1:0] LPMS_CLK_RESET = 2'h0;
  localparam logic [15:0] LPMS_TMR_RESET = 16'h0000;

  // Timing: system clock and periodic interval limit
  localparam int LPMS_CLK_MHZ = 100;
  localparam int LPMS_PERIOD_MAX_S = 2;
  localparam int LPMS_CLK_SETTLE_NS = 100;
  localparam int LPMS_CLK_SETTLE_CYC = (LPMS_CLK_SETTLE_NS * LPMS_CLK_MHZ + 999) / 1000;

  // Configuration bundle from the core side
  typedef struct packed {
    logic [1:0] mode_sel;
    logic deep_standby_select;
    logic [LPMS_WK_W-1:0] wake_enable;
  } lpms_cfg_t;

  // Cascaded timer reload values
  typedef struct packed {
    logic [15:0] first_reload;
    logic [15:0] second_reload;
  } lpms_tmr_cfg_t;

endpackage

// file: verif/lpms_chk.sv
`timescale 1ns/1ps
module lpms_chk
  import lpms_pkg::*;
#(
  parameter int PIN_W = 8,
  parameter int RTC_W = 32
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic wfi,
  input wire lpms_cfg_t cfg,
  input wire logic irq_pin,
  input wire logic slow_tick,
  input wire logic [PIN_W-1:0] pin_disabled,
  input wire logic core_halt,
  input wire logic [3:0] mode_state,
  input wire logic [1:0] clk_src,
  input wire logic [RTC_W-1:0] rtc_count,
  input wire logic wake_pulse,
  input wire logic deep_wake_reset,
  input wire logic deep_standby_reset_flag,
  input wire logic pin_state_retention,
  input wire logic [PIN_W-1:0] pad_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Mode entry and the standby branch
  a_sleep_entry:
    assert property (!core_halt && mode_state == 4'h0 && wfi && cfg.mode_sel == LPMS_SEL_SLEEP |=> mode_state == 4'h1)
    else $error("sleep entry missed");
  a_deep_via_sby:
    assert property (mode_state == 4'h2 && cfg.deep_standby_select |=> mode_state == 4'h8) else $error("deep entry missed");
  a_halt_in_mode:
    assert property (mode_state != 4'h0 |-> core_halt) else $error("core not halted");
  // Wake, clock, counter and disabled pin behaviour
  a_irq_wakes:
    assert property (mode_state == 4'h1 && cfg.wake_enable[0] && irq_pin |-> ##[1:20] wake_pulse) else $error("no wake");
  a_wake_single:
    assert property (wake_pulse |-> !core_halt ##1 !wake_pulse) else $error("wake pulse shape");
  a_clk_frozen:
    assert property (mode_state != 4'h0 |=> $stable(clk_src)) else $error("clock moved in mode");
  a_rtc_runs:
    assert property (slow_tick && core_halt |=> ##1 rtc_count == $past(rtc_count) + 1'b1) else $error("rtc stopped");
  a_deep_reset:
    assert property (deep_wake_reset |-> deep_standby_reset_flag && mode_state == 4'h0 ##1 !deep_wake_reset)
    else $error("deep wake reset shape");
  a_unused_input:
    assert property (!pin_state_retention |=> pin_state_retention || (pad_oe & $past(pin_disabled)) == '0)
    else $error("disabled pin driven");
  // Main scenarios reached
  c_sleep: cover property (mode_state == 4'h1 ##[1:30] wake_pulse);
  c_snooze: cover property (mode_state == 4'h4);
  c_deep: cover property (deep_wake_reset);
endmodule

// file: verif/lpms_core_model.sv
`timescale 1ns/1ps
module lpms_core_model (
  input wire logic clk_sys,
  input wire logic do_wfi,
  input wire logic do_irq,
  output logic wfi,
  output logic irq_pin,
  output logic slow_tick
);
  logic [1:0] div_r = 2'h0;
  // Core program issues the wait and the external wake line
  assign wfi = do_wfi;
  assign irq_pin = do_irq;
  // Slow count rate never stops, one pulse in four cycles
  assign slow_tick = (div_r == 2'h3);
  always @(negedge clk_sys) begin
    div_r <= div_r + 2'h1;
  end
endmodule

// file: verif/test_lpms_sequencer.sv
`timescale 1ns/1ps
module test_lpms_sequencer;
  import lpms_pkg::*;
  logic clk_sys = 0, reset_n = 0, do_wfi = 0, do_irq = 0, wfi, irq_pin, slow_tick;
  lpms_cfg_t cfg = '0;
  lpms_tmr_cfg_t tmr_cfg = '0;
  logic [31:0] alarm_value = '0, rtc_count;
  logic alarm_enable = 0, clk_src_wr = 0, pin_state_retention_clear = 0, deep_standby_reset_flag_clear = 0;
  logic [1:0] clk_src_req = '0, clk_src;
  logic [2:0] period_sel = 3'h0;
  logic [7:0] pin_disabled = '0, pin_out = 8'h5a, pin_oe = 8'hff, pad_out, pad_oe;
  logic core_halt, clk_gate, wake_pulse, deep_wake_reset, deep_standby_reset_flag, pin_state_retention;
  logic [3:0] mode_state;
  int mismatches = 0, n_compared = 0;
  lpms_core_model core (.clk_sys, .do_wfi, .do_irq, .wfi, .irq_pin, .slow_tick);
  lpms_sequencer uut (.clk_sys, .reset_n, .slow_tick, .wfi, .cfg, .tmr_cfg, .period_sel, .alarm_value,
    .alarm_enable, .irq_pin, .clk_src_req, .clk_src_wr, .pin_disabled, .pin_out, .pin_oe, .pin_state_retention_clear,
    .deep_standby_reset_flag_clear, .core_halt, .mode_state, .clk_src, .clk_gate, .rtc_count, .wake_pulse,
    .deep_wake_reset, .deep_standby_reset_flag, .pin_state_retention, .pad_out, .pad_oe);
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Bounded wait for the wake pulse, or for the deep wake reset when deep is set
  task automatic wait_hi(input bit deep, input string nm);
    for (int i = 0; i < 2000 && (deep ? deep_wake_reset : wake_pulse) !== 1'b1; i++) @(negedge clk_sys);
    chk(nm, deep ? deep_wake_reset : wake_pulse, 1);
  endtask
  // Configure a mode, then one wait request
  task automatic enter(input logic [1:0] sel, input logic deep, input logic [3:0] en);
    cfg = '{sel, deep, en};
    tick(1);
    do_wfi = 1;
    tick(1);
    do_wfi = 0;
  endtask
  task automatic t_pins;
    pin_disabled = 8'hf0;
    tick(2);
    chk("pad_oe", pad_oe, 8'h0f);
    chk("pad_out", pad_out, 8'h5a);
  endtask
  task automatic t_sleep;
    clk_src_req = 2'h2;
    clk_src_wr = 1;
    tick(1);
    clk_src_wr = 0;
    tick(1);
    chk("clk_src", clk_src, 2'h2);
    enter(LPMS_SEL_SLEEP, 0, 4'h1);
    chk("sleep", mode_state, 4'h1);
    chk("gate_sleep", clk_gate, 0);
    clk_src_req = 2'h1;
    clk_src_wr = 1;
    tick(1);
    clk_src_wr = 0;
    do_irq = 1;
    wait_hi(0, "irq_wake");
    do_irq = 0;
    chk("halt", core_halt, 0);
    chk("clk_kept", clk_src, 2'h2);
  endtask
  task automatic t_snooze;
    logic [31:0] t0;
    t0 = rtc_count;
    alarm_value = rtc_count + 32'h0000_000c;
    alarm_enable = 1;
    enter(LPMS_SEL_SNOOZE, 0, 4'h2);
    tick(1);
    chk("snooze", mode_state, 4'h4);
    chk("gate_snooze", clk_gate, 1);
    wait_hi(0, "alarm_wake");
    chk("rtc_run", (rtc_count - t0) >= 32'h0000_000c, 1);
    alarm_enable = 0;
  endtask
  // Over-long interval request: the clamp keeps the periodic wake at 64 slow ticks, 256 cycles
  task automatic t_periodic;
    int n;
    period_sel = 3'h7;
    enter(LPMS_SEL_SLEEP, 0, 4'h4);
    wait_hi(0, "periodic_wake");
    enter(LPMS_SEL_SLEEP, 0, 4'h4);
    n = 0;
    while (wake_pulse !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    chk("period_len", (n > 200) && (n < 300), 1);
  endtask
  task automatic t_deep;
    tmr_cfg = '{16'h0002, 16'h0001};
    // Let the timers take the new reloads before standby
    tick(8);
    enter(LPMS_SEL_STANDBY, 1, 4'h8);
    chk("standby", mode_state, 4'h2);
    tick(1);
    chk("deep", mode_state, 4'h8);
    tick(1);
    chk("retain", pin_state_retention, 1);
    pin_out = 8'ha5;
    wait_hi(1, "timer_wake");
    chk("flag", deep_standby_reset_flag, 1);
    tick(3);
    chk("retain_held", pin_state_retention, 1);
    chk("pad_held", pad_out, 8'h5a);
    pin_state_retention_clear = 1;
    deep_standby_reset_flag_clear = 1;
    tick(1);
    pin_state_retention_clear = 0;
    deep_standby_reset_flag_clear = 0;
    tick(1);
    chk("released", {pin_state_retention, deep_standby_reset_flag}, 2'h0);
    chk("pad_free", pad_out, 8'ha5);
  endtask
  initial begin
    tick(16);
    reset_n = 1;
    tick(1);
    t_pins();
    t_sleep();
    t_snooze();
    t_periodic();
    t_deep();
    stop_test();
  end
  // Hang guard, well past the expected run
  initial begin
    #50us;
    mismatches++;
    stop_test();
  end
endmodule
bind lpms_sequencer lpms_chk #(.PIN_W(PIN_W), .RTC_W(RTC_W)) chk_i (.clk_sys, .reset_n, .wfi, .cfg, .irq_pin,
  .slow_tick, .pin_disabled, .core_halt, .mode_state, .clk_src, .rtc_count, .wake_pulse, .deep_wake_reset,
  .deep_standby_reset_flag, .pin_state_retention, .pad_oe);
